/* File: pkg/cfg_header_pkg.sv */
// Constants and types for the configuration identity and command block
package cfg_header_pkg;

  // Configuration dword indices (256-byte space, 64 dwords)
  localparam logic [5:0] IDX_IDENT = 6'h00;
  localparam logic [5:0] IDX_CMD_STAT = 6'h01;
  localparam logic [5:0] IDX_CLASS_REV = 6'h02;
  localparam logic [5:0] IDX_LAYOUT = 6'h03;

  // Byte offsets of the class code bytes inside the space
  localparam logic [7:0] OFS_CLASS_PROG = 8'h09;
  localparam logic [7:0] OFS_CLASS_SUB = 8'h0A;
  localparam logic [7:0] OFS_CLASS_BASE = 8'h0B;

  // Field positions inside the dwords
  localparam int unsigned HALF_HI = 16;
  localparam int unsigned REV_LSB = 0;
  localparam int unsigned CLASS_LSB = 8;
  localparam int unsigned LAYOUT_LSB = 16;
  localparam int unsigned LAYOUT_MF_BIT = 7;

  // Standard header layout code for locations 10h..3Fh
  localparam logic [6:0] LAYOUT_STANDARD = 7'h00;

  // Command bit positions
  localparam int unsigned CMD_IO = 0;
  localparam int unsigned CMD_MEM = 1;
  localparam int unsigned CMD_MASTER = 2;
  localparam int unsigned CMD_SPECIAL = 3;
  localparam int unsigned CMD_MWI = 4;
  localparam int unsigned CMD_PALETTE = 5;
  localparam int unsigned CMD_PARITY = 6;
  localparam int unsigned CMD_STEP = 7;
  localparam int unsigned CMD_SERR = 8;
  localparam int unsigned CMD_FASTB2B = 9;
  localparam int unsigned CMD_WIDTH = 16;

  // Values used by the block
  localparam logic [15:0] CMD_ZERO = 16'h0000;
  localparam logic [31:0] DWORD_ZERO = 32'h0000_0000;

  // Address/data stepping capability
  localparam int STEP_NEVER = 0;
  localparam int STEP_ALWAYS = 1;
  localparam int STEP_OPTIONAL = 2;

  // Access sequencer phases
  typedef enum logic [0:0] {
    PH_IDLE,
    PH_ANSWER
  } phase_t;

endpackage

/* File: rtl/cfg_read_mux.sv */
// Read data selection for the configuration header dwords
module cfg_read_mux
  import cfg_header_pkg::*;
#(
  parameter logic [15:0] MAKER_ID = 16'h5A5A,
  parameter logic [15:0] PRODUCT_ID = 16'h0001,
  parameter logic [7:0] REVISION_IDENTIFIER = 8'h01,
  parameter logic [23:0] CLASS_CODE = 24'h08_8000,
  parameter bit MULTI_FUNCTION = 1'b0
) (
  input wire logic [5:0] i_index,
  input wire logic [15:0] i_command,
  output logic [31:0] o_data
);

  // Header layout byte: top bit 0 marks a multifunction device
  localparam logic [7:0] LAYOUT_BYTE = {~MULTI_FUNCTION, LAYOUT_STANDARD}; // RULE_05 RULE_06

  // Constant fields come from parameters only, so no write can reach them
  always_comb begin // RULE_01
    o_data = DWORD_ZERO;
    unique case (i_index)
      IDX_IDENT: begin
        o_data = {PRODUCT_ID, MAKER_ID}; // RULE_02 RULE_03
      end
      IDX_CMD_STAT: begin
        o_data = {16'h0000, i_command}; // RULE_20
      end
      IDX_CLASS_REV: begin
        o_data = {CLASS_CODE, REVISION_IDENTIFIER}; // RULE_04 RULE_07
      end
      IDX_LAYOUT: begin
        o_data[LAYOUT_LSB +: 8] = LAYOUT_BYTE;
      end
      default: begin
        o_data = DWORD_ZERO;
      end
    endcase
  end

endmodule

/* File: rtl/cfg_ident_command.sv */
// Configuration identity fields and Command register of a target-only board
// Function
// RULE_01 - Identity fields are read-only; writes never change them.
// RULE_02 - Maker field returns a fixed maker code.
// RULE_03 - Product field returns a fixed maker-chosen product code.
// RULE_04 - Revision field returns a fixed code extending the product code.
// RULE_05 - Layout byte top bit flags multifunction; 0 means multifunction.
// RULE_06 - Layout low seven bits return 00h, the standard header.
// RULE_07 - Class code: base 0Bh, subclass 0Ah, interface 09h, all read-only.
// RULE_08 - Command all zero: respond only to configuration accesses.
// RULE_09 - Command bit 0 gates I/O space response, resets to 0.
// RULE_10 - Command bit 1 gates memory space response, resets to 0.
// RULE_11 - Command bit 2 permits bus mastering, resets to 0.
// RULE_12 - Command bit 3 enables special cycle monitoring, resets to 0.
// RULE_13 - Command bit 4 allows write-and-invalidate, resets to 0.
// RULE_14 - Command bit 5 enables palette snooping, device then ignores palette accesses.
// RULE_15 - Command bit 6 enables parity-error action, resets to 0.
// RULE_16 - Command bit 7 stepping: fixed 0, fixed 1, or writable resetting to 1.
// RULE_17 - Command bit 8 enables error driver; address parity needs bits 8 and 6.
// RULE_18 - Command bit 9 optional writable fast back-to-back enable.
// RULE_19 - Configuration header is reachable at all times.
// RULE_20 - Implemented registers read back the value in use.
// RULE_21 - Command bits 10 to 15 read zero and ignore writes.
// RULE_22 - Unused functions (master, memory, special cycles) read fixed zero.
module cfg_ident_command
  import cfg_header_pkg::*;
#(
  parameter logic [15:0] MAKER_ID = 16'h5A5A,
  parameter logic [15:0] PRODUCT_ID = 16'h0001,
  parameter logic [7:0] REVISION_IDENTIFIER = 8'h01,
  parameter logic [23:0] CLASS_CODE = 24'h08_8000,
  parameter bit MULTI_FUNCTION = 1'b0,
  parameter bit PALETTE_IMPL = 1'b0,
  parameter int STEP_MODE = STEP_NEVER,
  parameter bit FAST_B2B_IMPL = 1'b1
) (
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire logic i_CLK_EN,
  input wire logic i_CFG_REQ,
  input wire logic i_CFG_WRITE,
  input wire logic [5:0] i_CFG_INDEX,
  input wire logic [3:0] i_CFG_BYTE_EN,
  input wire logic [31:0] i_CFG_WDATA,
  input wire logic i_IO_HIT,
  input wire logic i_MEM_HIT,
  input wire logic i_PALETTE_HIT,
  input wire logic i_PARITY_ERR,
  input wire logic i_ADDR_PARITY_ERR,
  output logic o_CFG_ACK,
  output logic [31:0] o_CFG_RDATA,
  output logic o_IO_ENABLE,
  output logic o_MEM_ENABLE,
  output logic o_MASTER_ENABLE,
  output logic o_SPECIAL_ENABLE,
  output logic o_MWI_ENABLE,
  output logic o_PALETTE_SNOOP,
  output logic o_PARITY_RESPONSE,
  output logic o_STEP_ENABLE,
  output logic o_SERR_ENABLE,
  output logic o_FAST_B2B_ENABLE,
  output logic o_IO_CLAIM,
  output logic o_MEM_CLAIM,
  output logic o_PERR_REPORT,
  output logic o_SERR_REPORT
);

  // Refuse stepping modes the logic does not know
  if (STEP_MODE < STEP_NEVER || STEP_MODE > STEP_OPTIONAL) begin : g_bad_step
    $error("STEP_MODE must be never, always or optional");
  end

  // Writable command bits for this board; all others stay at their fixed value
  localparam logic STEP_RW = (STEP_MODE == STEP_OPTIONAL);
  localparam logic STEP_FIXED = (STEP_MODE != STEP_NEVER);
  localparam logic [15:0] CMD_RW_MASK = {6'b00_0000, FAST_B2B_IMPL, 1'b1, STEP_RW,
    1'b1, PALETTE_IMPL, 5'b0_0001};
  localparam logic [15:0] CMD_FIXED = {8'h00, STEP_FIXED, 7'h00};
  localparam logic [15:0] CMD_RESET = CMD_FIXED;

  // Whole state of the block
  typedef struct packed {
    phase_t phase;
    logic ack;
    logic [31:0] rdata;
    logic [15:0] command;
    logic io_claim;
    logic mem_claim;
    logic perr_report;
    logic serr_report;
  } blk_state_t;

  localparam blk_state_t STATE_RESET = '{
    phase: PH_IDLE,
    ack: 1'b0,
    rdata: DWORD_ZERO,
    command: CMD_RESET,
    io_claim: 1'b0,
    mem_claim: 1'b0,
    perr_report: 1'b0,
    serr_report: 1'b0
  };

  blk_state_t st;
  blk_state_t next_st;
  logic [31:0] read_word;
  logic [15:0] cmd_written;
  logic cmd_write;
  logic take;

  // Read word for the requested dword
  cfg_read_mux #(
    .MAKER_ID(MAKER_ID),
    .PRODUCT_ID(PRODUCT_ID),
    .REVISION_IDENTIFIER(REVISION_IDENTIFIER),
    .CLASS_CODE(CLASS_CODE),
    .MULTI_FUNCTION(MULTI_FUNCTION)
  ) u_read_mux (
    .i_index(i_CFG_INDEX),
    .i_command(st.command),
    .o_data(read_word)
  );

  // A request is taken only in idle, whatever the command bits hold
  assign take = i_CFG_REQ && (st.phase == PH_IDLE); // RULE_19
  assign cmd_write = take && i_CFG_WRITE && (i_CFG_INDEX == IDX_CMD_STAT);

  // Per-bit update: writable bits follow the write, the rest stay fixed
  for (genvar b = 0; b < CMD_WIDTH; b++) begin : g_cmd_bit
    localparam int unsigned LANE = b / 8;
    always_comb begin
      if (!CMD_RW_MASK[b]) begin
        cmd_written[b] = CMD_FIXED[b]; // RULE_16 RULE_21 RULE_22
      end else if (cmd_write && i_CFG_BYTE_EN[LANE]) begin
        cmd_written[b] = i_CFG_WDATA[b]; // RULE_09 RULE_15 RULE_17 RULE_18
      end else begin
        cmd_written[b] = st.command[b];
      end
    end
  end

  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.command = cmd_written;
    // Target gating: a zero command claims nothing but configuration cycles
    next_st.io_claim = i_IO_HIT && st.command[CMD_IO] // RULE_08 RULE_09
      && !(i_PALETTE_HIT && st.command[CMD_PALETTE]); // RULE_14
    next_st.mem_claim = i_MEM_HIT && st.command[CMD_MEM] // RULE_10
      && !(i_PALETTE_HIT && st.command[CMD_PALETTE]); // RULE_14
    // Parity action only when enabled; address parity needs the error driver too
    next_st.perr_report = i_PARITY_ERR && st.command[CMD_PARITY]; // RULE_15
    next_st.serr_report = i_ADDR_PARITY_ERR && st.command[CMD_PARITY]
      && st.command[CMD_SERR]; // RULE_17
    unique case (st.phase)
      PH_IDLE: begin
        next_st.ack = 1'b0;
        if (take) begin
          next_st.phase = PH_ANSWER;
          next_st.ack = 1'b1;
          next_st.rdata = i_CFG_WRITE ? DWORD_ZERO : read_word; // RULE_20
        end
      end
      PH_ANSWER: begin
        next_st.phase = PH_IDLE;
        next_st.ack = 1'b0;
        next_st.rdata = DWORD_ZERO;
      end
    endcase
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st <= STATE_RESET;
    end else if (i_CLK_EN) begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign o_CFG_ACK = st.ack;
  assign o_CFG_RDATA = st.rdata;
  assign o_IO_ENABLE = st.command[CMD_IO];
  assign o_MEM_ENABLE = st.command[CMD_MEM];
  assign o_MASTER_ENABLE = st.command[CMD_MASTER]; // RULE_11
  assign o_SPECIAL_ENABLE = st.command[CMD_SPECIAL]; // RULE_12
  assign o_MWI_ENABLE = st.command[CMD_MWI]; // RULE_13
  assign o_PALETTE_SNOOP = st.command[CMD_PALETTE];
  assign o_PARITY_RESPONSE = st.command[CMD_PARITY];
  assign o_STEP_ENABLE = st.command[CMD_STEP];
  assign o_SERR_ENABLE = st.command[CMD_SERR];
  assign o_FAST_B2B_ENABLE = st.command[CMD_FASTB2B];
  assign o_IO_CLAIM = st.io_claim;
  assign o_MEM_CLAIM = st.mem_claim;
  assign o_PERR_REPORT = st.perr_report;
  assign o_SERR_REPORT = st.serr_report;

  // Checks on the block's own behaviour
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_N);

  sequence s_read_taken(logic [5:0] idx);
    i_CLK_EN && take && !i_CFG_WRITE && i_CFG_INDEX == idx;
  endsequence

  // Steps each used by a single check below
  sequence s_answer_cycle;
    i_CLK_EN && o_CFG_ACK;
  endsequence

  sequence s_write_taken;
    i_CLK_EN && take && i_CFG_WRITE;
  endsequence

  sequence s_serr_armed;
    o_PARITY_RESPONSE && o_SERR_ENABLE;
  endsequence

  // Maker and product read back the fixed codes
  ident_read_a: assert property ( // RULE_02
    s_read_taken(IDX_IDENT) ##1 o_CFG_ACK |-> o_CFG_RDATA == {PRODUCT_ID, MAKER_ID})
    else $error("identity dword read wrong");

  // Class and revision read back fixed
  class_read_a: assert property ( // RULE_07
    s_read_taken(IDX_CLASS_REV) ##1 o_CFG_ACK |-> o_CFG_RDATA == {CLASS_CODE, REVISION_IDENTIFIER})
    else $error("class and revision dword read wrong");

  // Layout byte carries flag and standard code
  layout_read_a: assert property ( // RULE_06
    s_read_taken(IDX_LAYOUT) ##1 o_CFG_ACK
      |-> o_CFG_RDATA == {8'h00, ~MULTI_FUNCTION, LAYOUT_STANDARD, 16'h0000})
    else $error("header layout byte wrong");

  // Command read returns the bits in use
  cmd_readback_a: assert property ( // RULE_20
    s_read_taken(IDX_CMD_STAT) |=> o_CFG_ACK && o_CFG_RDATA[15:0] == $past(st.command))
    else $error("command read does not match live bits");

  // Reserved and unused command bits hold their fixed value
  cmd_fixed_a: assert property ( // RULE_21
    (st.command & ~CMD_RW_MASK) == (CMD_FIXED & ~CMD_RW_MASK))
    else $error("fixed command bit changed");

  // A write with lane 0 enabled loads the I/O enable from the written bit
  io_write_a: assert property ( // RULE_09
    i_CLK_EN && cmd_write && i_CFG_BYTE_EN[0] |=> o_IO_ENABLE == $past(i_CFG_WDATA[CMD_IO]))
    else $error("I/O enable did not follow write");

  // No I/O claim while the I/O space enable is off
  io_gate_a: assert property ( // RULE_08
    i_CLK_EN && !o_IO_ENABLE |=> !o_IO_CLAIM)
    else $error("I/O claimed while disabled");

  // Address parity report needs both enables
  serr_gate_a: assert property ( // RULE_17
    o_SERR_REPORT |-> $past(o_SERR_ENABLE) && $past(o_PARITY_RESPONSE))
    else $error("system error reported while disabled");

  // Every accepted request is answered one enabled edge later
  ack_once_a: assert property ( // RULE_19
    i_CLK_EN && take |=> o_CFG_ACK)
    else $error("configuration answer missing");

  // The answer stands for a single enabled cycle
  ack_drop_a: assert property ( // RULE_19
    s_answer_cycle |=> !o_CFG_ACK)
    else $error("configuration answer longer than one cycle");

  // Write answers carry no data
  write_rdata_a: assert property ( // RULE_19
    s_write_taken |=> o_CFG_ACK && o_CFG_RDATA == DWORD_ZERO)
    else $error("write answer carried data");

  // Read data is zero outside the answer
  rdata_idle_a: assert property ( // RULE_20
    !o_CFG_ACK |-> o_CFG_RDATA == DWORD_ZERO)
    else $error("read data outside answer");

  // A low clock enable freezes every state bit
  freeze_hold_a: assert property ( // RULE_20
    !i_CLK_EN |=> $stable(st))
    else $error("state moved while clock enable low");

  // Only a command write moves the command bits
  cmd_hold_a: assert property ( // RULE_20
    i_CLK_EN && !cmd_write |=> $stable(st.command))
    else $error("command changed without a write");

  // Parity response follows a lane 0 write
  parity_write_a: assert property ( // RULE_15
    i_CLK_EN && cmd_write && i_CFG_BYTE_EN[0]
      |=> o_PARITY_RESPONSE == $past(i_CFG_WDATA[CMD_PARITY]))
    else $error("parity response did not follow write");

  // Error driver enable follows a lane 1 write
  serr_write_a: assert property ( // RULE_17
    i_CLK_EN && cmd_write && i_CFG_BYTE_EN[1]
      |=> o_SERR_ENABLE == $past(i_CFG_WDATA[CMD_SERR]))
    else $error("error driver enable did not follow write");

  // Fast back-to-back enable is writable only when implemented
  fastb2b_write_a: assert property ( // RULE_18
    i_CLK_EN && cmd_write && i_CFG_BYTE_EN[1]
      |=> o_FAST_B2B_ENABLE == ($past(i_CFG_WDATA[CMD_FASTB2B]) && FAST_B2B_IMPL))
    else $error("fast back-to-back enable did not follow write");

  // Functions this board lacks read as fixed zero
  unused_zero_a: assert property ( // RULE_22
    !o_MEM_ENABLE && !o_MASTER_ENABLE && !o_SPECIAL_ENABLE && !o_MWI_ENABLE)
    else $error("unimplemented function enabled");

  // No memory claim while memory space is off
  mem_gate_a: assert property ( // RULE_10
    i_CLK_EN && !o_MEM_ENABLE |=> !o_MEM_CLAIM)
    else $error("memory claimed while disabled");

  // An enabled I/O hit outside palette snooping is claimed
  io_claim_a: assert property ( // RULE_09
    i_CLK_EN && i_IO_HIT && o_IO_ENABLE && !(i_PALETTE_HIT && o_PALETTE_SNOOP)
      |=> o_IO_CLAIM)
    else $error("enabled I/O hit not claimed");

  // Palette accesses are left alone while snooping
  palette_gate_a: assert property ( // RULE_14
    i_CLK_EN && i_PALETTE_HIT && o_PALETTE_SNOOP |=> !o_IO_CLAIM && !o_MEM_CLAIM)
    else $error("palette access claimed while snooping");

  // Data parity report needs the parity response bit
  perr_gate_a: assert property ( // RULE_15
    o_PERR_REPORT |-> $past(o_PARITY_RESPONSE))
    else $error("parity error reported while disabled");

  // An enabled data parity error is reported
  perr_set_a: assert property ( // RULE_15
    i_CLK_EN && i_PARITY_ERR && o_PARITY_RESPONSE |=> o_PERR_REPORT)
    else $error("parity error not reported");

  // An address parity error with both enables on is reported
  serr_set_a: assert property ( // RULE_17
    i_CLK_EN && i_ADDR_PARITY_ERR ##0 s_serr_armed |=> o_SERR_REPORT)
    else $error("address parity error not reported");

endmodule

/* File: bench/cfg_host_model.sv */
// Host bridge model that issues configuration cycles to the block
module cfg_host_model (
  input wire logic i_clock,
  input wire logic i_ack,
  input wire logic [31:0] i_rdata,
  output logic o_req,
  output logic o_write,
  output logic [5:0] o_index,
  output logic [3:0] o_be,
  output logic [31:0] o_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus at time zero
  initial begin
    o_req = 1'b0;
    o_write = 1'b0;
    o_index = 6'h00;
    o_be = 4'h0;
    o_wdata = 32'h0000_0000;
  end

  // One cycle: drive after a falling edge, hold through the edge that sees the answer
  task automatic access(input logic wr, input logic [5:0] idx, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 32'h0000_0000;
    @(negedge i_clock);
    o_req = 1'b1;
    o_write = wr;
    o_index = idx;
    o_be = be;
    o_wdata = wd;
    for (n = 0; n < 4 && !ok; n++) begin
      @(negedge i_clock);
      if (i_ack === 1'b1) begin
        ok = 1'b1;
        rd = i_rdata;
      end
    end
    @(posedge i_clock);
    @(negedge i_clock);
    // Released lines carry the inverse of the last value, not a stale copy
    o_req = 1'b0;
    o_write = ~wr;
    o_index = ~idx;
    o_be = ~be;
    o_wdata = ~wd;
  endtask
endmodule

/* File: bench/tb_cfg_ident_command.sv */
// Self-checking bench for the configuration identity and command block
module tb_cfg_ident_command;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] MAKER = 16'hC3A7; // Arbitrary value
  localparam logic [15:0] PRODUCT = 16'h0B2E; // Arbitrary value
  localparam logic [7:0] REV = 8'h3D; // Arbitrary value
  localparam logic [23:0] CLASS = 24'h08_8000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic req, wr, ack, io_hit, mem_hit, perr, aperr, io_claim, mem_claim, perr_rep, serr_rep;
  logic pal_hit = 1'b0;
  logic [5:0] idx;
  logic [3:0] be;
  logic [31:0] wd, rdata;
  logic [9:0] en;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #2.5 clk = ~clk;

  cfg_host_model u_host (.i_clock(clk), .i_ack(ack), .i_rdata(rdata), .o_req(req),
    .o_write(wr), .o_index(idx), .o_be(be), .o_wdata(wd));

  cfg_ident_command #(.MAKER_ID(MAKER), .PRODUCT_ID(PRODUCT), .REVISION_IDENTIFIER(REV),
    .CLASS_CODE(CLASS), .PALETTE_IMPL(1'b1), .STEP_MODE(cfg_header_pkg::STEP_OPTIONAL))
  u_dut (.I_CLOCK(clk), .I_RST_N(rst_n), .i_CLK_EN(clk_en), .i_CFG_REQ(req),
    .i_CFG_WRITE(wr), .i_CFG_INDEX(idx), .i_CFG_BYTE_EN(be), .i_CFG_WDATA(wd),
    .i_IO_HIT(io_hit), .i_MEM_HIT(mem_hit), .i_PALETTE_HIT(pal_hit), .i_PARITY_ERR(perr),
    .i_ADDR_PARITY_ERR(aperr), .o_CFG_ACK(ack), .o_CFG_RDATA(rdata),
    .o_IO_ENABLE(en[0]), .o_MEM_ENABLE(en[1]), .o_MASTER_ENABLE(en[2]),
    .o_SPECIAL_ENABLE(en[3]), .o_MWI_ENABLE(en[4]), .o_PALETTE_SNOOP(en[5]),
    .o_PARITY_RESPONSE(en[6]), .o_STEP_ENABLE(en[7]), .o_SERR_ENABLE(en[8]),
    .o_FAST_B2B_ENABLE(en[9]), .o_IO_CLAIM(io_claim), .o_MEM_CLAIM(mem_claim),
    .o_PERR_REPORT(perr_rep), .o_SERR_REPORT(serr_rep));

  // Compare a word against its expected value
  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  // Compare a flag against its expected value
  task automatic chk_bit(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %b seen %b", name, exp, got);
    end
  endtask

  // Configuration read with the answer checked
  task automatic rd_chk(input logic [5:0] i, input logic [31:0] exp);
    logic [31:0] d;
    logic ok;
    u_host.access(1'b0, i, 4'hF, 32'h0000_0000, d, ok);
    chk_bit("read ack", 1'b1, ok);
    chk_word("read data", exp, d);
  endtask

  // Configuration write with the answer checked
  task automatic wr_do(input logic [5:0] i, input logic [3:0] b, input logic [31:0] w);
    logic [31:0] d;
    logic ok;
    u_host.access(1'b1, i, b, w, d, ok);
    chk_bit("write ack", 1'b1, ok);
  endtask

  // Present {io, mem, parity, address parity} for one cycle, check claims one edge later
  task automatic gate_chk(input logic [3:0] hits, input logic [3:0] exp);
    @(negedge clk);
    {io_hit, mem_hit, perr, aperr} = hits;
    @(negedge clk);
    {io_hit, mem_hit, perr, aperr} = 4'h0;
    chk_word("claims", {28'h0, exp}, {28'h0, io_claim, mem_claim, perr_rep, serr_rep});
  endtask

  // Final report and verdict
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      end_of_test;
    end
  end

  // Main sequence
  initial begin
    {io_hit, mem_hit, perr, aperr} = 4'h0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    chk_word("enables", 32'h0000_0080, {22'h0, en});
    rd_chk(6'h01, 32'h0000_0080);
    for (int k = 0; k < 2; k++) begin
      rd_chk(6'h00, {PRODUCT, MAKER});
      rd_chk(6'h02, {CLASS, REV});
      rd_chk(6'h03, 32'h0080_0000);
      rd_chk(6'h3F, 32'h0000_0000);
      wr_do(6'h00, 4'hF, 32'hFFFF_FFFF);
      wr_do(6'h02, 4'hF, 32'hFFFF_FFFF);
      wr_do(6'h03, 4'hF, 32'hFFFF_FFFF);
      wr_do(6'h3F, 4'hF, 32'hFFFF_FFFF);
    end
    wr_do(6'h01, 4'hF, 32'hFFFF_FFFF);
    rd_chk(6'h01, 32'h0000_03E1);
    chk_word("enables", 32'h0000_03E1, {22'h0, en});
    gate_chk(4'b1111, 4'b1011);
    // Palette hits are not claimed while snooping
    pal_hit = 1'b1;
    gate_chk(4'b1111, 4'b0011);
    pal_hit = 1'b0;
    wr_do(6'h01, 4'b0001, 32'h0000_0000);
    rd_chk(6'h01, 32'h0000_0300);
    gate_chk(4'b1111, 4'b0000);
    wr_do(6'h01, 4'b0011, 32'h0000_0141);
    // A low clock enable holds the claims at their idle value
    clk_en = 1'b0;
    gate_chk(4'b1111, 4'b0000);
    clk_en = 1'b1;
    gate_chk(4'b1111, 4'b1011);
    wr_do(6'h01, 4'b0011, 32'h0000_0100);
    gate_chk(4'b1111, 4'b0000);
    wr_do(6'h01, 4'b0011, 32'h0000_0000);
    gate_chk(4'b1111, 4'b0000);
    rd_chk(6'h00, {PRODUCT, MAKER});
    chk_word("enables", 32'h0000_0000, {22'h0, en});
    // Reset in mid-run brings the command back to its reset value
    wr_do(6'h01, 4'hF, 32'hFFFF_FFFF);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk_word("enables", 32'h0000_0080, {22'h0, en});
    rd_chk(6'h01, 32'h0000_0080);
    end_of_test;
  end
endmodule
